/* core/prvs_defines.svh */
`ifndef PRVS_DEFINES_SVH
`define PRVS_DEFINES_SVH

// Register index (byte offset = index * 4)
`define PRVS_IDX_ROM_BASE   2'h0
`define PRVS_IDX_IRQ_ROUTE  2'h1
`define PRVS_IDX_PAL_REDIR  2'h2

// Reset values
`define PRVS_RST_ROM_BASE   32'h00000000
`define PRVS_RST_IRQ_ROUTE  32'h00000100
`define PRVS_RST_PAL_REDIR  32'h81000002

// Field positions
`define PRVS_ROM_MSB_HI     31
`define PRVS_ROM_MSB_LO     18
`define PRVS_ROM_DE_BIT     0
`define PRVS_IRQ_PIN_VAL    8'h01
`define PRVS_IRQ_PIN_HI     15
`define PRVS_IRQ_PIN_LO     8
`define PRVS_IRQ_LINE_HI    7
`define PRVS_IRQ_LINE_LO    0
`define PRVS_PAL_VE_BIT     31
`define PRVS_PAL_DATA_HI    27
`define PRVS_PAL_DATA_LO    24
`define PRVS_PAL_ADDR_HI    7
`define PRVS_PAL_ADDR_LO    4
`define PRVS_PAL_MASK_HI    3
`define PRVS_PAL_MASK_LO    0

// Snooped I/O port addresses
`define PRVS_IO_PIX_MASK    16'h03c6
`define PRVS_IO_PIX_ADDR    16'h03c8
`define PRVS_IO_PIX_DATA    16'h03c9

`define PRVS_ZERO32         32'h00000000

`endif

/* core/prvs_pkg.sv */
`default_nettype none
package prvs_pkg;
   typedef enum logic [1:0] {
      PRVS_SNOOP_NONE = 2'b00,
      PRVS_SNOOP_DATA = 2'b01,
      PRVS_SNOOP_ADDR = 2'b10,
      PRVS_SNOOP_MASK = 2'b11
   } prvs_snoop_t;
endpackage
`default_nettype wire

/* core/prvs_snoop_decode.sv */
`timescale 1ns/1ns
`default_nettype none
`include "prvs_defines.svh"

module prvs_snoop_decode
   import prvs_pkg::*;
(
   // I/O write address
   input  wire logic [15:0] io_addr,
   // Result
   output logic [1:0]       hit_kind
);
   always_comb begin
      if (io_addr == `PRVS_IO_PIX_DATA) begin
         hit_kind = PRVS_SNOOP_DATA;
      end else if (io_addr == `PRVS_IO_PIX_ADDR) begin
         hit_kind = PRVS_SNOOP_ADDR;
      end else if (io_addr == `PRVS_IO_PIX_MASK) begin
         hit_kind = PRVS_SNOOP_MASK;
      end else begin
         hit_kind = PRVS_SNOOP_NONE;
      end
   end
endmodule // prvs_snoop_decode
`default_nettype wire

/* core/prvs_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "prvs_defines.svh"

module prvs_regs
   import prvs_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   // Configuration register port
   input  wire logic [1:0]  cfg_addr,
   input  wire logic [31:0] cfg_wdata,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   output logic [31:0]      cfg_rdata,
   // Command register bits held elsewhere
   input  wire logic        mem_space_en,
   input  wire logic        palette_snoop,
   // Memory access to check against the ROM window
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   output logic             rom_claim,
   // I/O write to snoop
   input  wire logic        io_wr,
   input  wire logic [15:0] io_addr,
   input  wire logic [31:0] io_wdata,
   output logic             io_claim,
   output logic             redir_valid,
   output logic [3:0]       redir_dest,
   output logic [7:0]       redir_data
);

   logic [13:0] rom_base_reg;
   logic        rom_decode_enable_reg;
   logic [7:0]  irq_line_reg;
   logic        palette_snoop_enable_reg;
   logic [3:0]  redir_data_f_reg;
   logic [3:0]  redir_addr_f_reg;
   logic [3:0]  redir_mask_f_reg;
   logic [31:0] rom_window_base;
   logic [31:0] interrupt_routing;
   logic [31:0] palette_redirect;
   logic [1:0]  hit_kind;
   logic        snoop_go;
   logic [3:0]  dest_sel;
   logic        wr_rom;
   logic        wr_irq;
   logic        wr_pal;

   // Register index match, shared by the write enables and the read mux
   function automatic logic reg_sel(input logic [1:0] addr, input logic [1:0] idx);
      return addr == idx;
   endfunction

   // Ones over bits hi down to lo; builds the live-bit masks below
   function automatic logic [31:0] field_mask(input int hi, input int lo);
      logic [31:0] m;
      m = `PRVS_ZERO32;
      for (int i = lo; i <= hi; i++) begin
         m[i] = 1'b1;
      end
      return m;
   endfunction

   function automatic int field_width(input int hi, input int lo);
      return hi - lo + 1;
   endfunction

   // Reset images held as typed constants so their fields can be selected
   localparam logic [31:0] ROM_RST_IMG = `PRVS_RST_ROM_BASE;
   localparam logic [31:0] IRQ_RST_IMG = `PRVS_RST_IRQ_ROUTE;
   localparam logic [31:0] PAL_RST_IMG = `PRVS_RST_PAL_REDIR;

   localparam logic [31:0] ROM_MSB_M  = field_mask(`PRVS_ROM_MSB_HI, `PRVS_ROM_MSB_LO);
   localparam logic [31:0] ROM_DE_M   = field_mask(`PRVS_ROM_DE_BIT, `PRVS_ROM_DE_BIT);
   localparam logic [31:0] IRQ_PIN_M  = field_mask(`PRVS_IRQ_PIN_HI, `PRVS_IRQ_PIN_LO);
   localparam logic [31:0] IRQ_LINE_M = field_mask(`PRVS_IRQ_LINE_HI, `PRVS_IRQ_LINE_LO);
   localparam logic [31:0] PAL_VE_M   = field_mask(`PRVS_PAL_VE_BIT, `PRVS_PAL_VE_BIT);
   localparam logic [31:0] PAL_DATA_M = field_mask(`PRVS_PAL_DATA_HI, `PRVS_PAL_DATA_LO);
   localparam logic [31:0] PAL_ADDR_M = field_mask(`PRVS_PAL_ADDR_HI, `PRVS_PAL_ADDR_LO);
   localparam logic [31:0] PAL_MASK_M = field_mask(`PRVS_PAL_MASK_HI, `PRVS_PAL_MASK_LO);
   localparam logic [31:0] PAL_REST_M = PAL_DATA_M | PAL_ADDR_M | PAL_MASK_M;

   localparam int          ROM_MSB_W  = field_width(`PRVS_ROM_MSB_HI, `PRVS_ROM_MSB_LO);
   localparam int          IRQ_LINE_W = field_width(`PRVS_IRQ_LINE_HI, `PRVS_IRQ_LINE_LO);
   localparam int          PAL_DATA_W = field_width(`PRVS_PAL_DATA_HI, `PRVS_PAL_DATA_LO);
   localparam int          PAL_ADDR_W = field_width(`PRVS_PAL_ADDR_HI, `PRVS_PAL_ADDR_LO);
   localparam int          PAL_MASK_W = field_width(`PRVS_PAL_MASK_HI, `PRVS_PAL_MASK_LO);

   // Elaboration checks: the layout in the defines must fit the storage here
   if (ROM_MSB_W != $bits(rom_base_reg)) begin : g_rom_width_chk
      $error("ROM base field width differs from its register");
   end
   if (IRQ_LINE_W != $bits(irq_line_reg)) begin : g_irq_width_chk
      $error("Interrupt line field width differs from its register");
   end
   if (PAL_DATA_W != $bits(redir_data_f_reg) || PAL_ADDR_W != $bits(redir_addr_f_reg)
       || PAL_MASK_W != $bits(redir_mask_f_reg)) begin : g_pal_width_chk
      $error("Redirect field width differs from its register");
   end
   if ((ROM_MSB_M & ROM_DE_M) != `PRVS_ZERO32 || (IRQ_PIN_M & IRQ_LINE_M) != `PRVS_ZERO32
       || (PAL_VE_M & PAL_REST_M) != `PRVS_ZERO32) begin : g_overlap_chk
      $error("Two register fields share a bit");
   end
   if ((PAL_DATA_M & PAL_ADDR_M) != `PRVS_ZERO32 || (PAL_DATA_M & PAL_MASK_M) != `PRVS_ZERO32
       || (PAL_ADDR_M & PAL_MASK_M) != `PRVS_ZERO32) begin : g_redir_overlap_chk
      $error("Two redirect fields share a bit");
   end
   // Reserved bits must reset to zero, or the read-as-zero promise breaks
   if ((ROM_RST_IMG & ~(ROM_MSB_M | ROM_DE_M)) != `PRVS_ZERO32) begin : g_rom_rst_chk
      $error("ROM base reset value sets a reserved bit");
   end
   if ((IRQ_RST_IMG & ~(IRQ_PIN_M | IRQ_LINE_M)) != `PRVS_ZERO32
       || IRQ_RST_IMG[`PRVS_IRQ_PIN_HI:`PRVS_IRQ_PIN_LO] != `PRVS_IRQ_PIN_VAL) begin : g_irq_chk
      $error("Interrupt reset value disagrees with its fixed pin field");
   end
   if ((PAL_RST_IMG & ~(PAL_VE_M | PAL_REST_M)) != `PRVS_ZERO32) begin : g_pal_rst_chk
      $error("Redirect reset value sets a reserved bit");
   end
   if (`PRVS_IDX_ROM_BASE == `PRVS_IDX_IRQ_ROUTE || `PRVS_IDX_ROM_BASE == `PRVS_IDX_PAL_REDIR
       || `PRVS_IDX_IRQ_ROUTE == `PRVS_IDX_PAL_REDIR) begin : g_index_chk
      $error("Two registers share one index");
   end

   assign wr_rom = cfg_wr && reg_sel(cfg_addr, `PRVS_IDX_ROM_BASE);
   assign wr_irq = cfg_wr && reg_sel(cfg_addr, `PRVS_IDX_IRQ_ROUTE);
   assign wr_pal = cfg_wr && reg_sel(cfg_addr, `PRVS_IDX_PAL_REDIR);

   // Read images; reserved bits come from constant zero, the fixed pin field from PRVS_IRQ_PIN_VAL
   always_comb begin
      rom_window_base = `PRVS_ZERO32;
      rom_window_base[`PRVS_ROM_MSB_HI:`PRVS_ROM_MSB_LO] = rom_base_reg;
      rom_window_base[`PRVS_ROM_DE_BIT] = rom_decode_enable_reg;
      interrupt_routing = `PRVS_ZERO32;
      interrupt_routing[`PRVS_IRQ_PIN_HI:`PRVS_IRQ_PIN_LO] = `PRVS_IRQ_PIN_VAL;
      interrupt_routing[`PRVS_IRQ_LINE_HI:`PRVS_IRQ_LINE_LO] = irq_line_reg;
      palette_redirect = `PRVS_ZERO32;
      palette_redirect[`PRVS_PAL_VE_BIT] = palette_snoop_enable_reg;
      palette_redirect[`PRVS_PAL_DATA_HI:`PRVS_PAL_DATA_LO] = redir_data_f_reg;
      palette_redirect[`PRVS_PAL_ADDR_HI:`PRVS_PAL_ADDR_LO] = redir_addr_f_reg;
      palette_redirect[`PRVS_PAL_MASK_HI:`PRVS_PAL_MASK_LO] = redir_mask_f_reg;
   end

   // ROM window base
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rom_base_reg          <= ROM_RST_IMG[`PRVS_ROM_MSB_HI:`PRVS_ROM_MSB_LO];
         rom_decode_enable_reg <= ROM_RST_IMG[`PRVS_ROM_DE_BIT];
      end else if (wr_rom) begin
         rom_base_reg          <= cfg_wdata[`PRVS_ROM_MSB_HI:`PRVS_ROM_MSB_LO];
         rom_decode_enable_reg <= cfg_wdata[`PRVS_ROM_DE_BIT];
      end
   end

   // Interrupt line
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         irq_line_reg <= IRQ_RST_IMG[`PRVS_IRQ_LINE_HI:`PRVS_IRQ_LINE_LO];
      end else if (wr_irq) begin
         irq_line_reg <= cfg_wdata[`PRVS_IRQ_LINE_HI:`PRVS_IRQ_LINE_LO];
      end
   end

   // Palette redirect
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         palette_snoop_enable_reg <= PAL_RST_IMG[`PRVS_PAL_VE_BIT];
         redir_data_f_reg         <= PAL_RST_IMG[`PRVS_PAL_DATA_HI:`PRVS_PAL_DATA_LO];
         redir_addr_f_reg         <= PAL_RST_IMG[`PRVS_PAL_ADDR_HI:`PRVS_PAL_ADDR_LO];
         redir_mask_f_reg         <= PAL_RST_IMG[`PRVS_PAL_MASK_HI:`PRVS_PAL_MASK_LO];
      end else if (wr_pal) begin
         palette_snoop_enable_reg <= cfg_wdata[`PRVS_PAL_VE_BIT];
         redir_data_f_reg         <= cfg_wdata[`PRVS_PAL_DATA_HI:`PRVS_PAL_DATA_LO];
         redir_addr_f_reg         <= cfg_wdata[`PRVS_PAL_ADDR_HI:`PRVS_PAL_ADDR_LO];
         redir_mask_f_reg         <= cfg_wdata[`PRVS_PAL_MASK_HI:`PRVS_PAL_MASK_LO];
      end
   end

   // Read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         cfg_rdata <= `PRVS_ZERO32;
      end else if (cfg_rd) begin
         if (reg_sel(cfg_addr, `PRVS_IDX_ROM_BASE)) begin
            cfg_rdata <= rom_window_base;
         end else if (reg_sel(cfg_addr, `PRVS_IDX_IRQ_ROUTE)) begin
            cfg_rdata <= interrupt_routing;
         end else if (reg_sel(cfg_addr, `PRVS_IDX_PAL_REDIR)) begin
            cfg_rdata <= palette_redirect;
         end else begin
            cfg_rdata <= `PRVS_ZERO32;
         end
      end else begin
         cfg_rdata <= `PRVS_ZERO32;
      end
   end

   // ROM claim: upper 14 address bits match, window is 256KB
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rom_claim <= 1'b0;
      end else begin
         rom_claim <= mem_req && rom_decode_enable_reg && mem_space_en
                      && (mem_addr[`PRVS_ROM_MSB_HI:`PRVS_ROM_MSB_LO] == rom_base_reg);
      end
   end

   prvs_snoop_decode u_decode (
      .io_addr  (io_addr),
      .hit_kind (hit_kind)
   );

   // Snoop only when both the enable and the command bit allow it
   assign snoop_go = io_wr && palette_snoop_enable_reg && palette_snoop
                     && (hit_kind != PRVS_SNOOP_NONE);

   always_comb begin
      case (hit_kind)
         PRVS_SNOOP_DATA: dest_sel = redir_data_f_reg;
         PRVS_SNOOP_ADDR: dest_sel = redir_addr_f_reg;
         PRVS_SNOOP_MASK: dest_sel = redir_mask_f_reg;
         default:         dest_sel = 4'h0;
      endcase
   end

   // Forwarded write, one-cycle pulse registered
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         io_claim    <= 1'b0;
         redir_valid <= 1'b0;
         redir_dest  <= 4'h0;
         redir_data  <= 8'h00;
      end else begin
         io_claim    <= snoop_go;
         redir_valid <= snoop_go;
         if (snoop_go) begin
            redir_dest <= dest_sel;
            redir_data <= io_wdata[7:0];
         end
      end
   end

endmodule // prvs_regs
`default_nettype wire

/* sim/prvs_regs_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module prvs_regs_sva (
   // Clock, reset and register port
   input wire logic        sys_clk, rst_b, cfg_wr, cfg_rd,
   input wire logic [1:0]  cfg_addr,
   input wire logic [31:0] cfg_wdata, cfg_rdata, io_wdata,
   // ROM window and snoop
   input wire logic        mem_space_en, palette_snoop, mem_req, rom_claim,
   input wire logic        io_wr, io_claim, redir_valid,
   input wire logic [15:0] io_addr,
   input wire logic [3:0]  redir_dest,
   input wire logic [7:0]  redir_data
);
   logic de_q;
   logic ve_q;
   // Shadows of the two enables, so the gates are judged from ports alone
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         de_q <= 1'b0;
         ve_q <= 1'b1;
      end else if (cfg_wr && cfg_addr == 2'h0) begin
         de_q <= cfg_wdata[0];
      end else if (cfg_wr && cfg_addr == 2'h2) begin
         ve_q <= cfg_wdata[31];
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   rdata_idle_a: assert property (!cfg_rd |=> cfg_rdata == 32'h0)
      else $error("read data not zero");
   mem_gate_a: assert property (mem_req && !mem_space_en |=> !rom_claim)
      else $error("claim without memory enable");
   decode_gate_a: assert property (rom_claim |-> $past(mem_req && de_q))
      else $error("claim without decode enable");
   snoop_fwd_a: assert property (io_wr && ve_q && palette_snoop && io_addr == 16'h03c9
      |=> redir_valid && io_claim && redir_data == $past(io_wdata[7:0]))
      else $error("pixel data write not forwarded");
   enable_gate_a: assert property (io_wr && !ve_q |=> !redir_valid && !io_claim)
      else $error("snoop while disabled");
   snoop_bit_a: assert property (io_wr && !palette_snoop |=> !redir_valid)
      else $error("snoop while command bit clear");
   valid_cause_a: assert property (redir_valid |-> $past(io_wr))
      else $error("forward without write");
   dest_hold_a: assert property (!redir_valid |->
      $stable(redir_dest) && $stable(redir_data))
      else $error("forward outputs moved");
   cover property (rom_claim);
   cover property (redir_valid);
   cover property (cfg_rd ##1 cfg_rdata != 32'h0);
endmodule // prvs_regs_sva
bind prvs_regs prvs_regs_sva u_sva (.sys_clk, .rst_b, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata,
   .cfg_rdata, .io_wdata, .mem_space_en, .palette_snoop, .mem_req, .rom_claim, .io_wr,
   .io_claim, .redir_valid, .io_addr, .redir_dest, .redir_data);
`default_nettype wire

/* sim/prvs_host.sv */
`timescale 1ns/1ns
`default_nettype none
module prvs_host (
   // Configuration cycles
   input  wire logic        sys_clk,
   output logic [1:0]       cfg_addr = 2'h0,
   output logic [31:0]      cfg_wdata = 32'h0,
   output logic             cfg_wr = 1'b0,
   output logic             cfg_rd = 1'b0,
   input  wire logic [31:0] cfg_rdata
);
   // Data inverted after the strobe so stale values never pass for valid
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      cfg_addr  <= a;
      cfg_wdata <= d;
      cfg_wr    <= 1'b1;
      @(posedge sys_clk);
      cfg_wr    <= 1'b0;
      cfg_wdata <= ~d;
   endtask
   task automatic rd(input logic [1:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      cfg_addr <= a;
      cfg_rd   <= 1'b1;
      @(posedge sys_clk);
      cfg_rd   <= 1'b0;
      @(negedge sys_clk);
      d = cfg_rdata;
   endtask
endmodule // prvs_host
`default_nettype wire

/* sim/pci_rom_irq_vga_snoop_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module pci_rom_irq_vga_snoop_regs_tb;
   logic        sys_clk = 1'b0, rst_b = 1'b0, cfg_wr, cfg_rd, rom_claim, io_claim, redir_valid;
   logic        mem_space_en = 1'b1, palette_snoop = 1'b1, mem_req = 1'b0, io_wr = 1'b0;
   logic [1:0]  cfg_addr;
   logic [31:0] cfg_wdata, cfg_rdata, rv, mem_addr = 32'h0, io_wdata = 32'h0;
   logic [15:0] io_addr = 16'h0;
   logic [3:0]  redir_dest;
   logic [7:0]  redir_data;
   int          errors = 0, compares = 0;
   always #25 sys_clk = ~sys_clk;
   prvs_host u_host (.sys_clk, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata);
   prvs_regs u_dut (.sys_clk, .rst_b, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata,
      .mem_space_en, .palette_snoop, .mem_req, .mem_addr, .rom_claim, .io_wr, .io_addr,
      .io_wdata, .io_claim, .redir_valid, .redir_dest, .redir_data);
   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic rdchk(input logic [1:0] a, input logic [31:0] e);
      u_host.rd(a, rv);
      chk(rv === e, "register read");
   endtask
   task automatic mem(input logic [31:0] a, input logic e);
      @(posedge sys_clk);
      mem_req  <= 1'b1;
      mem_addr <= a;
      @(posedge sys_clk);
      mem_req  <= 1'b0;
      mem_addr <= ~a;
      @(negedge sys_clk);
      chk(rom_claim === e, "rom claim");
   endtask
   // Upper lanes carry noise: only the low byte may be forwarded
   task automatic io(input logic [15:0] a, input logic [7:0] d, input logic e,
                     input logic [3:0] t);
      @(posedge sys_clk);
      io_wr    <= 1'b1;
      io_addr  <= a;
      io_wdata <= {24'ha5c3e1, d};
      @(posedge sys_clk);
      io_wr    <= 1'b0;
      @(negedge sys_clk);
      chk(redir_valid === e && io_claim === e, "snoop pulse");
      if (e) chk(redir_dest === t && redir_data === d, "redirect");
   endtask
   task automatic give_verdict;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      rdchk(2'h0, 32'h0);
      rdchk(2'h1, 32'h100);
      rdchk(2'h2, 32'h81000002);
      rdchk(2'h3, 32'h0);
      u_host.wr(2'h0, 32'hffffffff);
      rdchk(2'h0, 32'hfffc0001);
      mem(32'hfffc1234, 1'b1);
      mem(32'hfff81234, 1'b0);
      @(posedge sys_clk) mem_space_en <= 1'b0;
      mem(32'hfffc1234, 1'b0);
      @(posedge sys_clk) mem_space_en <= 1'b1;
      u_host.wr(2'h0, 32'hfffc0000);
      mem(32'hfffc1234, 1'b0);
      u_host.wr(2'h1, 32'hffffffff);
      rdchk(2'h1, 32'h1ff);
      io(16'h03c9, 8'h55, 1'b1, 4'h1);
      io(16'h03c8, 8'haa, 1'b1, 4'h0);
      io(16'h03c6, 8'h3c, 1'b1, 4'h2);
      io(16'h03c7, 8'h11, 1'b0, 4'h0);
      @(posedge sys_clk) palette_snoop <= 1'b0;
      io(16'h03c9, 8'h22, 1'b0, 4'h0);
      @(posedge sys_clk) palette_snoop <= 1'b1;
      u_host.wr(2'h2, 32'h7fffffff);
      rdchk(2'h2, 32'h0f0000ff);
      io(16'h03c9, 8'h33, 1'b0, 4'h0);
      u_host.wr(2'h2, 32'h85000073);
      io(16'h03c9, 8'h44, 1'b1, 4'h5);
      io(16'h03c8, 8'h66, 1'b1, 4'h7);
      io(16'h03c6, 8'h77, 1'b1, 4'h3);
      give_verdict();
   end
   initial begin
      #(3000 * 50);
      errors++;
      give_verdict();
   end
endmodule // pci_rom_irq_vga_snoop_regs_tb
`default_nettype wire
